// ### src/twm_pkg.sv
// Purpose: Shared constants for the timing and watchdog block.
// Assumes: Register index times four gives the AXI byte address.
// Notes: Reset values and field positions live only here.
package twm_pkg;
	localparam int ADDR_W = 26;
	// Register indices as printed; byte address is index * 4
	localparam logic [23:0] IDX_SETUP = 24'hFFFF20;
	localparam logic [23:0] IDX_PRESC = 24'hFFFF22;
	localparam logic [23:0] IDX_RELOAD = 24'hFFFF24;
	localparam logic [23:0] IDX_FLAGS = 24'hFFFF26;
	localparam logic [23:0] IDX_WDCOUNT = 24'hFFFF28;
	localparam logic [23:0] IDX_KEY = 24'hFFFF2A;
	// Internal select codes
	localparam logic [2:0] SEL_SETUP = 3'h0;
	localparam logic [2:0] SEL_PRESC = 3'h1;
	localparam logic [2:0] SEL_RELOAD = 3'h2;
	localparam logic [2:0] SEL_FLAGS = 3'h3;
	localparam logic [2:0] SEL_WDCOUNT = 3'h4;
	localparam logic [2:0] SEL_KEY = 3'h5;
	localparam logic [2:0] SEL_NONE = 3'h7;
	// Setup and locks register fields
	localparam int LOCK_SETUP_BIT = 0;
	localparam int LOCK_PRESC_BIT = 1;
	localparam int LOCK_TIMER_BIT = 2;
	localparam int LOCK_WATCHDOG_RELOAD_COUNT_BIT = 3;
	localparam int WD_CLK_SEL_BIT = 4;
	localparam int MATCH_EN_BIT = 5;
	localparam logic [7:0] SETUP_MASK = 8'h3F;
	localparam logic [7:0] LOCK_MASK = 8'h0F;
	// Timer control flags fields
	localparam int RESTART_BIT = 0;
	localparam int TC_BIT = 1;
	localparam int IRQ_EN_BIT = 2;
	localparam int LAST_TOUCH_BIT = 3;
	localparam int FREEZE_EN_BIT = 4;
	// Values after reset
	localparam logic [7:0] SETUP_RST = 8'h00;
	localparam logic [2:0] PRESC_RST = 3'h0;
	localparam logic [15:0] RELOAD_RST = 16'hFFFF;
	localparam logic [7:0] WDCOUNT_RST = 8'h0F;
	localparam logic [7:0] SERVICE_KEY = 8'h5C;
	// Slow clock cycles a service or restart stays in progress
	localparam logic [2:0] LAST_TOUCH_SLOW = 3'h5;
	// Power modes
	localparam logic [1:0] MODE_ACTIVE = 2'h0;
	localparam logic [1:0] MODE_IDLE = 2'h1;
	localparam logic [1:0] MODE_PSAVE = 2'h2;
	localparam logic [1:0] MODE_HALT = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [23:0] idx;
		idx = a[ADDR_W-1:2];
		if (idx == IDX_SETUP) return SEL_SETUP;
		if (idx == IDX_PRESC) return SEL_PRESC;
		if (idx == IDX_RELOAD) return SEL_RELOAD;
		if (idx == IDX_FLAGS) return SEL_FLAGS;
		if (idx == IDX_WDCOUNT) return SEL_WDCOUNT;
		if (idx == IDX_KEY) return SEL_KEY;
		return SEL_NONE;
	endfunction
endpackage

// ### src/twm_tick_if.sv
// Purpose: Tick and zero pulse carried from timer to watchdog.
// Assumes: All signals are one clk_in domain.
// Notes: zero_level lasts one tick period, zero_rise one cycle.
`timescale 1ns/1ps
interface twm_tick_if;
	logic tick;
	logic zero_rise;
	logic zero_level;
	modport src (output tick, output zero_rise, output zero_level);
	modport snk (input tick, input zero_rise, input zero_level);
endinterface // twm_tick_if

// ### src/periodic_tick_timer.sv
// Purpose: Slow clock prescaler and auto reloading periodic timer.
// Assumes: slow_en_in is a one-cycle pulse per slow clock period.
// Notes: Reload of zero is not supported by software contract.
`timescale 1ns/1ps
module periodic_tick_timer #(
	parameter int CNT_W = 16
) (
	// Clock, reset, freeze
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic run_in,
	// Control
	input wire logic slow_en_in,
	input wire logic [2:0] mdiv_in,
	input wire logic [CNT_W-1:0] reload_in,
	input wire logic restart_req_in,
	output logic restart_done_out,
	// Tick outputs
	twm_tick_if.src tick_bus
);
	logic [4:0] pcnt_r;
	logic [4:0] lim;
	logic tick_r;
	logic [CNT_W-1:0] cnt_r;
	logic zero_lvl_r;
	logic zero_rise_r;

	// Reserved divider codes fall back to the slowest rate
	assign lim = (mdiv_in > 3'h5) ? 5'h1F :
		5'((6'h01 << mdiv_in) - 6'h01);

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pcnt_r <= 5'h00;
			tick_r <= 1'b0;
		end else if (run_in) begin
			tick_r <= 1'b0;
			if (slow_en_in) begin
				if (pcnt_r >= lim) begin
					pcnt_r <= 5'h00;
					tick_r <= 1'b1;
				end else begin
					pcnt_r <= pcnt_r + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_r <= CNT_W'(twm_pkg::RELOAD_RST);
			zero_lvl_r <= 1'b0;
			zero_rise_r <= 1'b0;
			restart_done_out <= 1'b0;
		end else if (run_in) begin
			zero_rise_r <= 1'b0;
			restart_done_out <= 1'b0;
			if (tick_r) begin
				if (restart_req_in) begin
					cnt_r <= reload_in;
					restart_done_out <= 1'b1;
					zero_lvl_r <= 1'b0;
				end else if (cnt_r == CNT_W'(0)) begin
					cnt_r <= reload_in;
					zero_lvl_r <= 1'b0;
				end else begin
					cnt_r <= cnt_r - CNT_W'(1);
					if (cnt_r == CNT_W'(1)) begin
						zero_lvl_r <= 1'b1;
						zero_rise_r <= 1'b1;
					end
				end
			end
		end
	end

	assign tick_bus.tick = tick_r;
	assign tick_bus.zero_rise = zero_rise_r;
	assign tick_bus.zero_level = zero_lvl_r;
endmodule // periodic_tick_timer

// ### src/watchdog_core.sv
// Purpose: Eight bit watchdog with count or key servicing.
// Assumes: Write pulses are already filtered for lock and mode.
// Notes: err_out is a one-cycle pulse; caller makes it sticky.
`timescale 1ns/1ps
module watchdog_core #(
	parameter int WD_W = 8
) (
	// Clock, reset, freeze
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic run_in,
	// Configuration
	input wire logic clk_sel_in,
	input wire logic match_en_in,
	// Service writes
	input wire logic count_wr_in,
	input wire logic key_wr_in,
	input wire logic [WD_W-1:0] wr_data_in,
	input wire logic [WD_W-1:0] count_in,
	// Status
	output logic err_out,
	output logic started_out,
	twm_tick_if.snk tick_bus
);
	logic step;
	logic good_key;
	logic bad_key;
	logic count_svc;
	logic seen_r;
	logic [WD_W-1:0] cnt_r;

	assign step = clk_sel_in ? tick_bus.tick : tick_bus.zero_rise;
	assign good_key = key_wr_in && match_en_in &&
		(wr_data_in == twm_pkg::SERVICE_KEY);
	assign bad_key = key_wr_in && match_en_in &&
		(wr_data_in != twm_pkg::SERVICE_KEY);
	assign count_svc = count_wr_in && !match_en_in;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			started_out <= 1'b0;
		else if (run_in && (count_wr_in || key_wr_in))
			started_out <= 1'b1;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_r <= WD_W'(twm_pkg::WDCOUNT_RST);
		end else if (run_in) begin
			if (!started_out && count_wr_in)
				cnt_r <= wr_data_in;
			else if (!started_out && key_wr_in)
				cnt_r <= count_in;
			else if (count_svc)
				cnt_r <= wr_data_in;
			else if (good_key)
				cnt_r <= count_in;
			else if (started_out && step && cnt_r != WD_W'(0))
				cnt_r <= cnt_r - WD_W'(1);
		end
	end

	// Remembers a key service inside the current watchdog period
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			seen_r <= 1'b0;
		else if (run_in)
			seen_r <= good_key || (seen_r && !step);
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			err_out <= 1'b0;
		else if (run_in)
			err_out <= bad_key || (good_key && seen_r) ||
				(started_out && step && !count_svc && !good_key &&
				cnt_r <= WD_W'(1));
	end
endmodule // watchdog_core

// ### src/timing_guard_module.sv
// Purpose: Timing and watchdog unit with AXI4-Lite registers.
// Assumes: slow_en_in pulses once per slow clock period.
// Notes: Halt mode and ce_in low freeze everything, bus included.
// Overview of operation
// - Prescaler divides slow clock by 1..32.
// - Periodic timer counts down each tick.
// - At zero, timer reloads from reload register.
// - Zero pulse lasts one tick, sets flag.
// - Zero pulse gives gated irq, wakeup edge.
// - New reload value waits for next reload.
// - Restart bit reloads on next tick, self-clears.
// - Eight bit watchdog, idle after reset.
// - First count or key write starts it.
// - Clock select: zero pulse or tick.
// - Count mode: count write reloads, key ignored.
// - Key mode: 5Ch reloads stored count.
// - Key mode: other key value is error.
// - Late servicing, or too frequent key servicing, is error.
// - Watchdog error resets the whole device.
// - Locked registers ignore writes, read zero.
// - Lock bits set-only; others reset zero.
// - Which lock guards which register.
// - Low power: counters run, key only.
// - Halt freezes all, resumes in place.
// - Two key services per period is error.
`timescale 1ns/1ps
module timing_guard_module (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Slow clock strobe and power mode
	input wire logic slow_en_in,
	input wire logic [1:0] power_mode_in,
	// AXI4-Lite write address and data
	input wire logic axi_awvalid_in,
	output logic axi_awready_out,
	input wire logic [twm_pkg::ADDR_W-1:0] axi_awaddr_in,
	input wire logic axi_wvalid_in,
	output logic axi_wready_out,
	input wire logic [31:0] axi_wdata_in,
	input wire logic [3:0] axi_wstrb_in,
	// AXI4-Lite write response
	output logic axi_bvalid_out,
	input wire logic axi_bready_in,
	output logic [1:0] axi_bresp_out,
	// AXI4-Lite read
	input wire logic axi_arvalid_in,
	output logic axi_arready_out,
	input wire logic [twm_pkg::ADDR_W-1:0] axi_araddr_in,
	output logic axi_rvalid_out,
	input wire logic axi_rready_in,
	output logic [31:0] axi_rdata_out,
	output logic [1:0] axi_rresp_out,
	// Events
	output logic periodic_irq_out,
	output logic wakeup_edge_out,
	output logic device_reset_out
);
	logic run;
	logic active;
	logic aw_got_r;
	logic w_got_r;
	logic [2:0] aw_sel_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_fire;
	logic wr_ok;
	logic we_setup;
	logic we_presc;
	logic we_reload;
	logic we_flags;
	logic we_wdcount;
	logic we_key;
	logic [7:0] setup_r;
	logic [2:0] presc_r;
	logic [15:0] reload_r;
	logic restart_r;
	logic tc_r;
	logic irq_en_r;
	logic freeze_en_r;
	logic [7:0] wdcount_r;
	logic [2:0] touch_r;
	logic [2:0] ar_sel;
	logic rd_fire;
	logic rd_ok;
	logic [31:0] rd_data;
	logic restart_done;
	logic wd_err;
	logic wd_started;

	twm_tick_if tick_bus ();

	// Halt stops the whole unit so it resumes exactly in place
	assign run = ce_in && (power_mode_in != twm_pkg::MODE_HALT);
	assign active = (power_mode_in == twm_pkg::MODE_ACTIVE);

	// Write channel: either order; nothing is taken while frozen
	assign axi_awready_out = run && !aw_got_r && !axi_bvalid_out;
	assign axi_wready_out = run && !w_got_r && !axi_bvalid_out;
	assign wr_fire = aw_got_r && w_got_r && !axi_bvalid_out;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			aw_got_r <= 1'b0;
			aw_sel_r <= twm_pkg::SEL_NONE;
		end else if (run) begin
			if (axi_awvalid_in && axi_awready_out) begin
				aw_got_r <= 1'b1;
				aw_sel_r <= twm_pkg::reg_sel(axi_awaddr_in);
			end else if (wr_fire) begin
				aw_got_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			w_got_r <= 1'b0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else if (run) begin
			if (axi_wvalid_in && axi_wready_out) begin
				w_got_r <= 1'b1;
				wdata_r <= axi_wdata_in;
				wstrb_r <= axi_wstrb_in;
			end else if (wr_fire) begin
				w_got_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			axi_bvalid_out <= 1'b0;
			axi_bresp_out <= twm_pkg::RESP_OKAY;
		end else if (run) begin
			if (wr_fire) begin
				axi_bvalid_out <= 1'b1;
				axi_bresp_out <= (aw_sel_r == twm_pkg::SEL_NONE) ?
					twm_pkg::RESP_SLVERR : twm_pkg::RESP_OKAY;
			end else if (axi_bready_in) begin
				axi_bvalid_out <= 1'b0;
			end
		end
	end

	// Only the key register is reachable outside active mode
	assign wr_ok = wr_fire && wstrb_r[0] &&
		(active || aw_sel_r == twm_pkg::SEL_KEY);
	assign we_setup = wr_ok && aw_sel_r == twm_pkg::SEL_SETUP &&
		!setup_r[twm_pkg::LOCK_SETUP_BIT];
	assign we_presc = wr_ok && aw_sel_r == twm_pkg::SEL_PRESC &&
		!setup_r[twm_pkg::LOCK_PRESC_BIT];
	assign we_reload = wr_ok && aw_sel_r == twm_pkg::SEL_RELOAD &&
		!setup_r[twm_pkg::LOCK_TIMER_BIT];
	assign we_flags = wr_ok && aw_sel_r == twm_pkg::SEL_FLAGS &&
		!setup_r[twm_pkg::LOCK_TIMER_BIT];
	assign we_wdcount = wr_ok && aw_sel_r == twm_pkg::SEL_WDCOUNT &&
		!setup_r[twm_pkg::LOCK_WATCHDOG_RELOAD_COUNT_BIT];
	assign we_key = wr_ok && aw_sel_r == twm_pkg::SEL_KEY;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			setup_r <= twm_pkg::SETUP_RST;
		else if (run && we_setup)
			setup_r <= (wdata_r[7:0] & twm_pkg::SETUP_MASK) |
				(setup_r & twm_pkg::LOCK_MASK);
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			presc_r <= twm_pkg::PRESC_RST;
		else if (run && we_presc)
			presc_r <= wdata_r[2:0];
	end

	// Upper byte follows its own strobe; current count is untouched
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reload_r <= twm_pkg::RELOAD_RST;
		end else if (run && we_reload) begin
			reload_r[7:0] <= wdata_r[7:0];
			if (wstrb_r[1])
				reload_r[15:8] <= wdata_r[15:8];
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_en_r <= 1'b0;
			freeze_en_r <= 1'b0;
		end else if (run && we_flags) begin
			irq_en_r <= wdata_r[twm_pkg::IRQ_EN_BIT];
			freeze_en_r <= wdata_r[twm_pkg::FREEZE_EN_BIT];
		end
	end

	// Writing one requests a restart; the write wins over completion
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			restart_r <= 1'b0;
		else if (run && we_flags && wdata_r[twm_pkg::RESTART_BIT])
			restart_r <= 1'b1;
		else if (run && restart_done)
			restart_r <= 1'b0;
	end

	// Terminal count clears on read, a new zero pulse wins
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			tc_r <= 1'b0;
		else if (run && tick_bus.zero_rise)
			tc_r <= 1'b1;
		else if (run && rd_ok && ar_sel == twm_pkg::SEL_FLAGS)
			tc_r <= 1'b0;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			wdcount_r <= twm_pkg::WDCOUNT_RST;
		else if (run && we_wdcount)
			wdcount_r <= wdata_r[7:0];
	end

	// Busy window so software knows when power save is safe
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			touch_r <= 3'h0;
		else if (run && ((we_flags && wdata_r[twm_pkg::RESTART_BIT]) ||
			(we_wdcount && !setup_r[twm_pkg::MATCH_EN_BIT])))
			touch_r <= twm_pkg::LAST_TOUCH_SLOW;
		else if (run && slow_en_in && touch_r != 3'h0)
			touch_r <= touch_r - 3'h1;
	end

	// Read channel: one read outstanding, answer one cycle later
	assign axi_arready_out = run && !axi_rvalid_out;
	assign ar_sel = twm_pkg::reg_sel(axi_araddr_in);
	assign rd_fire = axi_arvalid_in && axi_arready_out;
	assign rd_ok = rd_fire && active && !(
		(ar_sel == twm_pkg::SEL_SETUP &&
			setup_r[twm_pkg::LOCK_SETUP_BIT]) ||
		(ar_sel == twm_pkg::SEL_PRESC &&
			setup_r[twm_pkg::LOCK_PRESC_BIT]) ||
		((ar_sel == twm_pkg::SEL_RELOAD ||
			ar_sel == twm_pkg::SEL_FLAGS) &&
			setup_r[twm_pkg::LOCK_TIMER_BIT]));

	always_comb begin
		rd_data = 32'h00000000;
		if (rd_ok) begin
			unique case (ar_sel)
				twm_pkg::SEL_SETUP: rd_data[7:0] = setup_r;
				twm_pkg::SEL_PRESC: rd_data[2:0] = presc_r;
				twm_pkg::SEL_RELOAD: rd_data[15:0] = reload_r;
				twm_pkg::SEL_FLAGS: begin
					rd_data[twm_pkg::RESTART_BIT] = restart_r;
					rd_data[twm_pkg::TC_BIT] = tc_r;
					rd_data[twm_pkg::IRQ_EN_BIT] = irq_en_r;
					rd_data[twm_pkg::LAST_TOUCH_BIT] = (touch_r != 3'h0);
					rd_data[twm_pkg::FREEZE_EN_BIT] = freeze_en_r;
				end
				default: rd_data = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			axi_rvalid_out <= 1'b0;
			axi_rdata_out <= 32'h00000000;
			axi_rresp_out <= twm_pkg::RESP_OKAY;
		end else if (run) begin
			if (rd_fire) begin
				axi_rvalid_out <= 1'b1;
				axi_rdata_out <= rd_data;
				axi_rresp_out <= (ar_sel == twm_pkg::SEL_NONE) ?
					twm_pkg::RESP_SLVERR : twm_pkg::RESP_OKAY;
			end else if (axi_rready_in) begin
				axi_rvalid_out <= 1'b0;
			end
		end
	end

	periodic_tick_timer #(
		.CNT_W(16)
	) u_timer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.run_in(run),
		.slow_en_in(slow_en_in),
		.mdiv_in(presc_r),
		.reload_in(reload_r),
		.restart_req_in(restart_r),
		.restart_done_out(restart_done),
		.tick_bus(tick_bus)
	);

	watchdog_core #(
		.WD_W(8)
	) u_watchdog (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.run_in(run),
		.clk_sel_in(setup_r[twm_pkg::WD_CLK_SEL_BIT]),
		.match_en_in(setup_r[twm_pkg::MATCH_EN_BIT]),
		.count_wr_in(we_wdcount),
		.key_wr_in(we_key),
		.wr_data_in(wdata_r[7:0]),
		.count_in(wdcount_r),
		.err_out(wd_err),
		.started_out(wd_started),
		.tick_bus(tick_bus)
	);

	assign periodic_irq_out = tick_bus.zero_level && irq_en_r;
	assign wakeup_edge_out = tick_bus.zero_level;

	// Held until the system reset it requests comes back
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			device_reset_out <= 1'b0;
		else if (run && wd_err)
			device_reset_out <= 1'b1;
	end

	property p_lock_sticky;
		@(posedge clk_in) disable iff (sys_rst_in)
		1'b1 |=> ((setup_r & $past(setup_r) & twm_pkg::LOCK_MASK) ==
			($past(setup_r) & twm_pkg::LOCK_MASK));
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock bit cleared without reset");

	property p_presc_locked;
		@(posedge clk_in) disable iff (sys_rst_in)
		(wr_fire && aw_sel_r == twm_pkg::SEL_PRESC &&
			setup_r[twm_pkg::LOCK_PRESC_BIT]) |=> $stable(presc_r);
	endproperty
	a_presc_locked: assert property (p_presc_locked)
		else $error("locked prescaler register changed");

	property p_lowpower_reload;
		@(posedge clk_in) disable iff (sys_rst_in)
		(wr_fire && !active && aw_sel_r == twm_pkg::SEL_RELOAD) |=>
			$stable(reload_r);
	endproperty
	a_lowpower_reload: assert property (p_lowpower_reload)
		else $error("reload written outside active mode");

	property p_zero_sets_tc;
		@(posedge clk_in) disable iff (sys_rst_in)
		(tick_bus.zero_rise && run) |=> tc_r ##0 tick_bus.zero_level;
	endproperty
	a_zero_sets_tc: assert property (p_zero_sets_tc)
		else $error("zero pulse did not set terminal count");

	property p_irq_gate;
		@(posedge clk_in) disable iff (sys_rst_in)
		periodic_irq_out |-> (irq_en_r && wakeup_edge_out);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt without enable or zero pulse");

	property p_restart_clears;
		@(posedge clk_in) disable iff (sys_rst_in)
		(restart_done && run && !we_flags) |=> !restart_r;
	endproperty
	a_restart_clears: assert property (p_restart_clears)
		else $error("restart bit stuck after restart");

	property p_bad_key;
		@(posedge clk_in) disable iff (sys_rst_in)
		(run && ce_in && we_key && setup_r[twm_pkg::MATCH_EN_BIT] &&
			wdata_r[7:0] != twm_pkg::SERVICE_KEY) |=>
			wd_err ##1 device_reset_out;
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("wrong key did not reset device");

	property p_idle_no_err;
		@(posedge clk_in) disable iff (sys_rst_in)
		(!wd_started && !we_key) |=> !wd_err;
	endproperty
	a_idle_no_err: assert property (p_idle_no_err)
		else $error("watchdog error before start");

	property p_reset_held;
		@(posedge clk_in) disable iff (sys_rst_in)
		$rose(device_reset_out) |=> device_reset_out [*8];
	endproperty
	a_reset_held: assert property (p_reset_held)
		else $error("device reset request dropped");
endmodule // timing_guard_module

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the timing guard module.
// Assumes: slow_en_in pulses every fourth clock.
// Notes: Locked and write-only reads are expected as zero.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
num_errors++; $display("mismatch t=%0t got %h exp %h", $time, g, e); \
end end
module tb_top;
	logic clk_in = 0;
	logic sys_rst_in = 1;
	logic slow_en_in = 0;
	logic [1:0] pm = 0;
	logic ce = 1;
	logic awv = 0, awr, wv = 0, wr_q, bv, br = 0, arv = 0, arr, rv, rr = 0;
	logic irq, wake, drst;
	logic [25:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd, d, e;
	logic [1:0] bresp, rresp, r;
	logic [1:0] sc = 0;
	int num_errors = 0, check_count = 0, t;
	int exp_reg[8];
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		sc <= sc + 2'h1;
		slow_en_in <= (sc == 2'h3);
	end
	timing_guard_module dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.ce_in(ce), .slow_en_in(slow_en_in), .power_mode_in(pm),
		.axi_awvalid_in(awv), .axi_awready_out(awr), .axi_awaddr_in(awa),
		.axi_wvalid_in(wv), .axi_wready_out(wr_q), .axi_wdata_in(wd),
		.axi_wstrb_in(4'hF), .axi_bvalid_out(bv), .axi_bready_in(br),
		.axi_bresp_out(bresp), .axi_arvalid_in(arv), .axi_arready_out(arr),
		.axi_araddr_in(ara), .axi_rvalid_out(rv), .axi_rready_in(rr),
		.axi_rdata_out(rd), .axi_rresp_out(rresp), .periodic_irq_out(irq),
		.wakeup_edge_out(wake), .device_reset_out(drst));
	task tally_and_finish;
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task hang;
		num_errors++;
		$display("mismatch t=%0t wait expired", $time);
		tally_and_finish();
	endtask
	function automatic bit lk(int s);
		int b[6] = '{0, 1, 2, 2, 3, 9};
		return s < 5 && exp_reg[0][b[s]];
	endfunction
	function automatic logic [31:0] mrd(int s);
		return (pm != 0 || lk(s) || s > 3) ? 32'h0 : 32'(exp_reg[s]);
	endfunction
	// Model of what software can see; access rules mirror the device
	task automatic mdl(int s, logic [31:0] v);
		if (pm != 0 || lk(s))
			return;
		if (s == 0)
			exp_reg[0] = (v & 'h3F) | (exp_reg[0] & 'h0F);
		else if (s == 1)
			exp_reg[1] = v & 7;
		else if (s == 2)
			exp_reg[2] = v & 'hFFFF;
	endtask
	task automatic wr(int s, logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_in);
		awa <= {24'hFFFF20 + 24'(2 * s), 2'b00};
		wd <= v;
		awv <= 1;
		wv <= 1;
		br <= 1;
		do begin
			@(posedge clk_in);
			n++;
			if (awr) awv <= 0;
			if (wr_q) wv <= 0;
			if (n > 300) hang();
		end while (!bv);
		r = bresp;
		br <= 0;
		if (r == twm_pkg::RESP_OKAY) mdl(s, v);
	endtask
	task automatic rdr(int s);
		int n;
		n = 0;
		e = mrd(s);
		@(posedge clk_in);
		ara <= {24'hFFFF20 + 24'(2 * s), 2'b00};
		arv <= 1;
		rr <= 1;
		do begin
			@(posedge clk_in);
			n++;
			if (arr) arv <= 0;
			if (n > 300) hang();
		end while (!rv);
		d = rd;
		r = rresp;
		rr <= 0;
	endtask
	task automatic do_rst;
		sys_rst_in <= 1;
		pm <= 0;
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 0;
		exp_reg = '{0, 0, 'hFFFF, 0, 0, 0, 0, 0};
	endtask
	task automatic wait_rst(int lim);
		for (int n = 0; n < lim && drst !== 1'b1; n++)
			@(posedge clk_in);
	endtask
	// Rise-to-rise distance of the third irq pulse, so config settles
	task automatic per;
		int n, k, last;
		logic p;
		n = 0;
		k = 0;
		last = 0;
		p = irq;
		while (k < 3) begin
			@(posedge clk_in);
			n++;
			if (irq && !p) begin
				k++;
				`CHK(wake, 1'b1)
				t = n - last;
				last = n;
			end
			p = irq;
			if (n > 3000) hang();
		end
	endtask
	initial begin
		void'($urandom(32'hd806));
		do_rst();
		for (int s = 0; s < 6; s++) begin
			rdr(s);
			`CHK(d, e)
		end
		rdr(8);
		`CHK(r, twm_pkg::RESP_SLVERR)
		repeat (4) begin
			wr(2, $urandom_range(16'hFFFF, 1));
			rdr(2);
			`CHK(d, e)
		end
		pm <= 1;
		wr(2, 5);
		pm <= 0;
		rdr(2);
		`CHK(d, 32'(exp_reg[2]))
		wr(2, 2);
		wr(3, 5);
		for (int c = 0; c < 6; c++) begin
			wr(1, c);
			per();
			`CHK(t, 12 * (1 << c))
		end
		rdr(3);
		`CHK(d[2:1], 2'b11)
		wr(3, 5);
		rdr(3);
		`CHK(d[3], 1'b1)
		repeat (150) @(posedge clk_in);
		rdr(3);
		`CHK(d[0], 1'b0)
		wr(0, 2);
		wr(1, 3);
		rdr(1);
		`CHK(d, e)
		wr(0, 0);
		rdr(0);
		`CHK(d, 32'h2)
		do_rst();
		wr(0, 'h10);
		repeat (100) @(posedge clk_in);
		`CHK(drst, 1'b0)
		wr(4, 3);
		pm <= 3;
		repeat (60) @(posedge clk_in);
		ce <= 0;
		pm <= 0;
		repeat (60) @(posedge clk_in);
		`CHK(drst, 1'b0)
		ce <= 1;
		wait_rst(200);
		`CHK(drst, 1'b1)
		do_rst();
		wr(0, 'h10);
		repeat (12) wr(4, 5);
		wr(5, 'h11);
		repeat (3) @(posedge clk_in);
		`CHK(drst, 1'b0)
		do_rst();
		wr(0, 'h30);
		wr(4, 6);
		repeat (3) begin
			repeat (6) @(posedge clk_in);
			wr(5, 'h5C);
		end
		repeat (3) @(posedge clk_in);
		`CHK(drst, 1'b0)
		wr(5, 'h5B);
		wait_rst(10);
		`CHK(drst, 1'b1)
		do_rst();
		wr(0, 'h20);
		wr(4, 40);
		wr(5, 'h5C);
		wr(5, 'h5C);
		wait_rst(10);
		`CHK(drst, 1'b1)
		tally_and_finish();
	end
endmodule // tb_top
